// *** hdl/gdp_regs.svh ***
// Offsets, field positions, reset values and timing figures of the driver
`ifndef GDP_REGS_SVH
`define GDP_REGS_SVH

// Register byte offsets
`define GDP_REG_CTRL 8'h00
`define GDP_REG_STATUS 8'h04
`define GDP_REG_FCNT 8'h08

// Control fields
`define GDP_CTRL_FORCE_OFF 0
`define GDP_CTRL_SENSOR_EN 1
`define GDP_CTRL_RESET 2'h2

// Status fields
`define GDP_ST_UVLO_IN 0
`define GDP_ST_UVLO_OUT 1
`define GDP_ST_FAULT 2
`define GDP_ST_DISABLED 3
`define GDP_ST_GATE_ON 4
`define GDP_ST_SOFT 5
`define GDP_ST_CLR_ARMED 6

// Analog levels in millivolts
`define GDP_VDD_ON_MV 12000
`define GDP_VDD_HYST_MV 800
`define GDP_CLAMP_MV 2000
`define GDP_OC_MV 700

// Times in nanoseconds
`define GDP_CLK_NS 4
`define GDP_INFIL_NS 40
`define GDP_MUTE_NS 5000
`define GDP_RSTFIL_NS 1000
`define GDP_RSTPD_NS 2000
`define GDP_UVLO_DGL_NS 5000
`define GDP_SOFT_OFF_NS 2000

`endif

// *** hdl/gdp_pkg.sv ***
// Types of the gate driver protection block
package gdp_pkg;

  typedef enum logic [1:0]
  {
    gdp_g_off = 2'b00,
    gdp_g_on = 2'b01,
    gdp_g_soft = 2'b11
  } gdp_gate_t;

  typedef struct packed
  {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [2:0] in_f;
    logic [2:0][7:0] flt_cnt;
    logic uvlo_in;
    logic uvlo_out;
    logic [23:0] dgl_in;
    logic [23:0] dgl_out;
    gdp_gate_t gate;
    logic [23:0] soft_cnt;
    logic fault;
    logic [23:0] mute_cnt;
    logic [23:0] rst_lo_cnt;
    logic [23:0] arm_cnt;
    logic clr_armed;
    logic disabled;
    logic [1:0] ctrl;
    logic [15:0] fault_cnt;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic gate_output;
    logic gate_soft_off;
    logic gate_pull_low;
    logic clamp_en;
    logic oc_pulldown_en;
    logic fault_out_n_oe;
    logic pg_oe;
    logic sensor_pwm_out;
    logic vdd_ref_high;
  } gdp_state_t;

endpackage

// *** hdl/gdp_gate_prot.sv ***
// Protection and control logic of an isolated gate driver
// Notes on behaviour
// [RULE_01] Either supply in lockout holds gate low
// [RULE_02] Gate high only with both supplies good
// [RULE_03] Output supply trips at 12 V, 800 mV hysteresis
// [RULE_04] Supply comparisons deglitched against brief dips
// [RULE_05] Power good open drain, low during lockout
// [RULE_06] Sensor PWM output held low during lockout
// [RULE_07] Clamp switch on when gate below threshold
// [RULE_08] Sense node pulled low while gate low
// [RULE_09] Sense pulldown released while gate high
// [RULE_10] Overcurrent when sense exceeds 0.7 V
// [RULE_11] Overcurrent starts soft turn-off, reports fault
// [RULE_12] After fault gate latched low until reset
// [RULE_13] Fault output open drain, overcurrent only
// [RULE_14] Fault output low until valid reset
// [RULE_15] Reset requests ignored during fault mute time
// [RULE_16] Low past filter time, clear on rise
// [RULE_17] Enable pin pulled down, host drives high
// [RULE_18] Long low on enable disables, soft off
// [RULE_19] Pulses under 40 ns filtered out
// [RULE_20] Gate high: noninverting high, inverting low
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "gdp_regs.svh"

module gdp_gate_prot
  import gdp_pkg::*;
#(
  parameter int MUTE_NS = `GDP_MUTE_NS,
  parameter int RSTFIL_NS = `GDP_RSTFIL_NS,
  parameter int RSTPD_NS = `GDP_RSTPD_NS,
  parameter int UVLO_DGL_NS = `GDP_UVLO_DGL_NS,
  parameter int SOFT_OFF_NS = `GDP_SOFT_OFF_NS
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host pins
  input wire logic in_pos,
  input wire logic in_neg,
  input wire logic rst_en,
  // Analog comparators and sensor encoder
  input wire logic vcc_cmp,
  input wire logic vdd_cmp,
  input wire logic overcurrent_sense,
  input wire logic clamp_cmp,
  input wire logic sensor_pwm_raw,
  // Drive stage and analog controls
  output logic gate_output,
  output logic gate_soft_off,
  output logic gate_pull_low,
  output logic clamp_en,
  output logic oc_pulldown_en,
  output logic vdd_ref_high,
  // Open-drain and sensor pins
  output logic fault_out_n_oe,
  output logic pg_oe,
  output logic sensor_pwm_out,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  localparam int CLK_NS = `GDP_CLK_NS;
  localparam int INFIL_CYC = (`GDP_INFIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int MUTE_CYC = (MUTE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTFIL_CYC = (RSTFIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTPD_CYC = (RSTPD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DGL_CYC = (UVLO_DGL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SOFT_CYC = (SOFT_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] INFIL_LAST = 8'(INFIL_CYC - 1);
  localparam logic [23:0] MUTE_LOAD = 24'(MUTE_CYC);
  localparam logic [23:0] RSTFIL_LAST = 24'(RSTFIL_CYC - 1);
  localparam logic [23:0] RSTPD_LAST = 24'(RSTPD_CYC - 1);
  localparam logic [23:0] DGL_LAST = 24'(DGL_CYC - 1);
  localparam logic [23:0] SOFT_LAST = 24'(SOFT_CYC - 1);
  localparam logic [23:0] CNT_MAX = 24'hFFFFFF;

  gdp_state_t s;
  gdp_state_t next_s;

  logic [7:0] raw;
  logic drive_req;
  logic allow;
  logic uvlo_any;
  logic oc_hit;
  logic rst_rise;
  logic [31:0] status_word;
  logic [1:0] ctrl_view;

  assign raw = {sensor_pwm_raw, clamp_cmp, overcurrent_sense, vdd_cmp,
                vcc_cmp, rst_en, in_neg, in_pos};

  always_comb
  begin
    next_s = s;
    // Two-stage synchronisers on every host, comparator and sensor pin
    next_s.sync1 = raw;
    next_s.sync2 = s.sync1;

    // Deglitch: a level must differ for INFIL_CYC cycles to pass
    for (int k = 0; k < 3; k++)
    begin
      if (s.sync2[k] == s.in_f[k])
      begin
        next_s.flt_cnt[k] = 8'h00;
      end
      else if (s.flt_cnt[k] == INFIL_LAST)
      begin
        next_s.flt_cnt[k] = 8'h00;
        next_s.in_f[k] = s.sync2[k]; // see [RULE_19]
      end
      else
      begin
        next_s.flt_cnt[k] = s.flt_cnt[k] + 8'h01;
      end
    end

    // Input supply lockout with deglitch
    if (s.sync2[3] != s.uvlo_in)
    begin
      next_s.dgl_in = 24'h000000;
    end
    else if (s.dgl_in == DGL_LAST)
    begin
      next_s.dgl_in = 24'h000000;
      next_s.uvlo_in = !s.sync2[3]; // see [RULE_04]
    end
    else
    begin
      next_s.dgl_in = s.dgl_in + 24'h000001;
    end

    // Output supply lockout; comparator level follows the state
    if (s.sync2[4] != s.uvlo_out)
    begin
      next_s.dgl_out = 24'h000000;
    end
    else if (s.dgl_out == DGL_LAST)
    begin
      next_s.dgl_out = 24'h000000;
      next_s.uvlo_out = !s.sync2[4]; // see [RULE_03] see [RULE_04]
    end
    else
    begin
      next_s.dgl_out = s.dgl_out + 24'h000001;
    end

    // Enable pin low time and disable
    if (s.in_f[2])
    begin
      next_s.rst_lo_cnt = 24'h000000;
      next_s.disabled = 1'b0; // see [RULE_17]
    end
    else
    begin
      if (s.rst_lo_cnt != CNT_MAX)
      begin
        next_s.rst_lo_cnt = s.rst_lo_cnt + 24'h000001;
      end
      if (s.rst_lo_cnt >= RSTPD_LAST)
      begin
        next_s.disabled = 1'b1; // see [RULE_18]
      end
    end

    // Fault mute and reset arming
    if (s.mute_cnt != 24'h000000)
    begin
      next_s.mute_cnt = s.mute_cnt - 24'h000001;
    end
    if (!s.fault || s.mute_cnt != 24'h000000 || s.in_f[2])
    begin
      next_s.arm_cnt = 24'h000000; // see [RULE_15]
    end
    else if (s.arm_cnt != CNT_MAX)
    begin
      next_s.arm_cnt = s.arm_cnt + 24'h000001;
    end
    if (!s.fault)
    begin
      next_s.clr_armed = 1'b0;
    end
    else if (s.arm_cnt >= RSTFIL_LAST && !s.in_f[2])
    begin
      next_s.clr_armed = 1'b1; // see [RULE_16]
    end
    rst_rise = next_s.in_f[2] && !s.in_f[2];
    if (s.fault && s.clr_armed && rst_rise)
    begin
      next_s.fault = 1'b0; // see [RULE_14] see [RULE_16]
    end

    // Gate state machine
    uvlo_any = s.uvlo_in || s.uvlo_out;
    drive_req = s.in_f[0] && !s.in_f[1]; // see [RULE_20]
    allow = !uvlo_any && !s.disabled && !s.fault
            && !s.ctrl[`GDP_CTRL_FORCE_OFF]; // see [RULE_02] see [RULE_12]
    oc_hit = s.sync2[5]; // see [RULE_10]
    next_s.soft_cnt = 24'h000000;
    case (s.gate)
      gdp_g_off:
      begin
        if (allow && drive_req)
        begin
          next_s.gate = gdp_g_on;
        end
      end
      gdp_g_on:
      begin
        if (uvlo_any)
        begin
          next_s.gate = gdp_g_off; // see [RULE_01]
        end
        else if (oc_hit)
        begin
          next_s.gate = gdp_g_soft; // see [RULE_11]
          next_s.fault = 1'b1; // see [RULE_11] see [RULE_13]
          next_s.mute_cnt = MUTE_LOAD; // see [RULE_15]
          next_s.fault_cnt = s.fault_cnt + 16'h0001;
        end
        else if (s.disabled || s.ctrl[`GDP_CTRL_FORCE_OFF])
        begin
          next_s.gate = gdp_g_soft; // see [RULE_18]
        end
        else if (!drive_req)
        begin
          next_s.gate = gdp_g_off;
        end
      end
      gdp_g_soft:
      begin
        if (uvlo_any || s.soft_cnt == SOFT_LAST)
        begin
          next_s.gate = gdp_g_off; // see [RULE_01]
        end
        else
        begin
          next_s.soft_cnt = s.soft_cnt + 24'h000001;
        end
      end
      default:
      begin
        next_s.gate = gdp_g_off;
      end
    endcase

    // Registered pin outputs
    next_s.gate_output = next_s.gate == gdp_g_on;
    next_s.gate_soft_off = next_s.gate == gdp_g_soft;
    next_s.gate_pull_low = next_s.gate == gdp_g_off;
    next_s.oc_pulldown_en = next_s.gate != gdp_g_on; // see [RULE_08] see [RULE_09]
    next_s.clamp_en = next_s.gate != gdp_g_on && s.sync2[6]; // see [RULE_07]
    next_s.fault_out_n_oe = next_s.fault; // see [RULE_13]
    next_s.pg_oe = next_s.uvlo_in || next_s.uvlo_out; // see [RULE_05]
    next_s.sensor_pwm_out = !(next_s.uvlo_in || next_s.uvlo_out)
                            && s.ctrl[`GDP_CTRL_SENSOR_EN]
                            && s.sync2[7]; // see [RULE_06]
    next_s.vdd_ref_high = next_s.uvlo_out; // see [RULE_03]

    // AHB-Lite data phase: writes
    ctrl_view = s.ctrl;
    if (s.ap_valid && s.ap_write && s.ap_addr == `GDP_REG_CTRL)
    begin
      ctrl_view = hwdata[1:0];
      next_s.ctrl = hwdata[1:0];
    end

    // AHB-Lite address phase: capture and prepare read data
    status_word = 32'h00000000;
    status_word[`GDP_ST_UVLO_IN] = s.uvlo_in;
    status_word[`GDP_ST_UVLO_OUT] = s.uvlo_out;
    status_word[`GDP_ST_FAULT] = s.fault;
    status_word[`GDP_ST_DISABLED] = s.disabled;
    status_word[`GDP_ST_GATE_ON] = s.gate == gdp_g_on;
    status_word[`GDP_ST_SOFT] = s.gate == gdp_g_soft;
    status_word[`GDP_ST_CLR_ARMED] = s.clr_armed;
    next_s.ap_valid = hsel && htrans[1] && hready;
    next_s.ap_write = hwrite;
    next_s.ap_addr = haddr[7:0];
    next_s.hrdata = 32'h00000000;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      if (haddr[7:0] == `GDP_REG_CTRL)
      begin
        next_s.hrdata = {30'h00000000, ctrl_view};
      end
      else if (haddr[7:0] == `GDP_REG_STATUS)
      begin
        next_s.hrdata = status_word;
      end
      else if (haddr[7:0] == `GDP_REG_FCNT)
      begin
        next_s.hrdata = {16'h0000, s.fault_cnt};
      end
    end
    next_s.hreadyout = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.uvlo_in <= 1'b1;
      s.uvlo_out <= 1'b1;
      s.disabled <= 1'b1;
      s.gate <= gdp_g_off;
      s.ctrl <= `GDP_CTRL_RESET;
      s.gate_pull_low <= 1'b1;
      s.oc_pulldown_en <= 1'b1;
      s.pg_oe <= 1'b1;
      s.vdd_ref_high <= 1'b1;
      s.hreadyout <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign gate_output = s.gate_output;
  assign gate_soft_off = s.gate_soft_off;
  assign gate_pull_low = s.gate_pull_low;
  assign clamp_en = s.clamp_en;
  assign oc_pulldown_en = s.oc_pulldown_en;
  assign vdd_ref_high = s.vdd_ref_high;
  assign fault_out_n_oe = s.fault_out_n_oe;
  assign pg_oe = s.pg_oe;
  assign sensor_pwm_out = s.sensor_pwm_out;
  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;

  // Assertions
  localparam int A_INFIL = INFIL_CYC;
  localparam int A_DGL = DGL_CYC;
  localparam int A_RSTPD = RSTPD_CYC;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_uvlo_gate_low: assert property ( // see [RULE_01]
    (s.uvlo_in || s.uvlo_out) |=> !gate_output)
    else $error("gate high during lockout");
  chk_gate_needs_pwr: assert property ( // see [RULE_02]
    gate_output |-> $past(!s.uvlo_in && !s.uvlo_out))
    else $error("gate raised without good supplies");
  chk_vdd_ref_level: assert property ( // see [RULE_03]
    $rose(s.uvlo_out) |=> vdd_ref_high)
    else $error("comparator level not raised in lockout");
  chk_uvlo_deglitch: assert property ( // see [RULE_04]
    $rose(s.uvlo_out) |-> $past(s.dgl_out) == A_DGL - 1)
    else $error("lockout entered before deglitch time");
  chk_pg_pulled_low: assert property ( // see [RULE_05]
    (s.uvlo_in || s.uvlo_out) |-> pg_oe)
    else $error("power good released in lockout");
  chk_sensor_pwm_low: assert property ( // see [RULE_06]
    (s.uvlo_in || s.uvlo_out) |-> !sensor_pwm_out)
    else $error("sensor pwm active in lockout");
  chk_clamp_cause: assert property ( // see [RULE_07]
    clamp_en |-> !gate_output && $past(s.sync2[6]))
    else $error("clamp on without low gate");
  chk_oc_pulldown: assert property ( // see [RULE_08]
    gate_output != oc_pulldown_en)
    else $error("sense pulldown wrong for gate state");
  chk_fault_soft_off: assert property ( // see [RULE_11]
    $rose(s.fault) |-> gate_soft_off && fault_out_n_oe
                       && $past(s.gate == gdp_g_on && s.sync2[5]))
    else $error("fault without soft turn-off");
  chk_fault_latch: assert property ( // see [RULE_12]
    s.fault |=> !gate_output)
    else $error("gate high with latched fault");
  chk_fault_clear: assert property ( // see [RULE_16]
    $fell(s.fault) |-> $rose(s.in_f[2]) && $past(s.clr_armed))
    else $error("fault cleared without valid reset");
  chk_mute_ignore: assert property ( // see [RULE_15]
    (s.fault && s.mute_cnt != 0) |=> s.fault && !s.clr_armed)
    else $error("reset accepted during mute time");
  chk_disable_hold: assert property ( // see [RULE_18]
    $rose(s.disabled) |-> $past(s.rst_lo_cnt) >= A_RSTPD - 1)
    else $error("driver disabled too early");
  chk_input_filter: assert property ( // see [RULE_19]
    $changed(s.in_f[0]) |-> $past(s.flt_cnt[0]) == A_INFIL - 1)
    else $error("input passed filter too early");

  cov_fault_hit: cover property ($rose(s.fault));
  cov_fault_reset: cover property ($fell(s.fault));
  cov_soft_done: cover property (
    s.gate == gdp_g_soft ##1 s.gate == gdp_g_off);
  cov_uvlo_exit: cover property ($fell(s.uvlo_out));

endmodule

// *** tb/gdp_host_model.sv ***
// Host model driving the PWM and reset/enable pins
`timescale 1ns/1ps

module gdp_host_model
(
  // Clock
  input wire logic clk_sys,
  // Pins towards the driver
  output logic in_pos,
  output logic in_neg,
  output logic rst_en
);
  initial
  begin
    in_pos = 1'b0;
    in_neg = 1'b0;
    rst_en = 1'b0; // Floating pin reads low
  end

  task automatic set_pwm(input logic p, input logic n);
    in_pos <= p;
    in_neg <= n;
  endtask

  task automatic set_en(input logic v);
    rst_en <= v; // Driven high to enable
  endtask

  // Low for n cycles, then a rising edge
  task automatic clear_req(input int n);
    rst_en <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rst_en <= 1'b1;
  endtask
endmodule

// *** tb/gdp_gate_prot_test.sv ***
// Self-checking bench of the gate driver protection block
`timescale 1ns/1ps

module gdp_gate_prot_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic vcc_cmp = 1'b0;
  logic vdd_cmp = 1'b0;
  logic overcurrent_sense = 1'b0;
  logic clamp_cmp = 1'b0;
  logic sensor_pwm_raw = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] r = 32'hD3E1;
  logic [31:0] q;
  logic seen;
  logic p;
  logic n;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  wire logic in_pos, in_neg, rst_en, hready;
  logic gate_output, gate_soft_off, gate_pull_low, clamp_en;
  logic oc_pulldown_en, vdd_ref_high, fault_out_n_oe, pg_oe;
  logic sensor_pwm_out, hreadyout;
  logic [31:0] hrdata;

  assign hready = hreadyout;

  gdp_host_model gdp_host_model_i
  (
    .clk_sys(clk_sys),
    .in_pos(in_pos),
    .in_neg(in_neg),
    .rst_en(rst_en)
  );

  gdp_gate_prot #(
    .MUTE_NS(200),
    .RSTFIL_NS(100),
    .RSTPD_NS(200),
    .UVLO_DGL_NS(200),
    .SOFT_OFF_NS(200)
  ) gdp_gate_prot_i
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_pos(in_pos),
    .in_neg(in_neg),
    .rst_en(rst_en),
    .vcc_cmp(vcc_cmp),
    .vdd_cmp(vdd_cmp),
    .overcurrent_sense(overcurrent_sense),
    .clamp_cmp(clamp_cmp),
    .sensor_pwm_raw(sensor_pwm_raw),
    .gate_output(gate_output),
    .gate_soft_off(gate_soft_off),
    .gate_pull_low(gate_pull_low),
    .clamp_en(clamp_en),
    .oc_pulldown_en(oc_pulldown_en),
    .vdd_ref_high(vdd_ref_high),
    .fault_out_n_oe(fault_out_n_oe),
    .pg_oe(pg_oe),
    .sensor_pwm_out(sensor_pwm_out),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp()
  );

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic wt(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic chk_pin(input string s, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %b seen %b", s, e, g);
    end
  endtask

  task automatic chk_reg(input string s, input logic [31:0] e,
                         input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // One single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string s, input logic [31:0] a,
                        input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk_reg(s, e, v);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 12000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    wt(6);
    rst <= 1'b0;
    wt(2);
    chk_pin("pg_oe", 1'b1, pg_oe);
    chk_pin("gate_output", 1'b0, gate_output);
    chk_pin("vdd_ref_high", 1'b1, vdd_ref_high);
    chk_pin("fault_out_n_oe", 1'b0, fault_out_n_oe);
    rd_chk("ctrl", 32'h0, 32'h2);
    rd_chk("unmapped", 32'hC, 32'h0);
    vcc_cmp <= 1'b1;
    vdd_cmp <= 1'b1;
    gdp_host_model_i.set_en(1'b1);
    wt(80);
    chk_pin("pg_oe", 1'b0, pg_oe);
    chk_pin("vdd_ref_high", 1'b0, vdd_ref_high);
    rd_chk("status", 32'h4, 32'h0);
    done("power up");
    for (int i = 0; i < 12; i++)
    begin
      r = lfsr(r);
      p = (i < 4) ? i[1] : r[0];
      n = (i < 4) ? i[0] : r[1];
      gdp_host_model_i.set_pwm(p, n);
      sensor_pwm_raw <= r[2];
      wt(20);
      chk_pin("gate_output", p & ~n, gate_output);
      chk_pin("oc_pulldown_en", ~(p & ~n), oc_pulldown_en);
      chk_pin("sensor_pwm_out", r[2], sensor_pwm_out);
    end
    gdp_host_model_i.set_pwm(1'b0, 1'b0);
    wt(20);
    gdp_host_model_i.set_pwm(1'b1, 1'b0);
    wt(8);
    gdp_host_model_i.set_pwm(1'b0, 1'b0);
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge clk_sys);
      seen = seen | gate_output;
    end
    chk_pin("short pulse", 1'b0, seen);
    clamp_cmp <= 1'b1;
    wt(6);
    chk_pin("clamp_en", 1'b1, clamp_en);
    clamp_cmp <= 1'b0;
    overcurrent_sense <= 1'b1;
    wt(10);
    chk_pin("clamp_en", 1'b0, clamp_en);
    chk_pin("fault_out_n_oe", 1'b0, fault_out_n_oe);
    overcurrent_sense <= 1'b0;
    done("pwm");
    gdp_host_model_i.set_pwm(1'b1, 1'b0);
    sensor_pwm_raw <= 1'b1;
    wt(20);
    vdd_cmp <= 1'b0;
    wt(5);
    vdd_cmp <= 1'b1;
    wt(10);
    chk_pin("gate_output", 1'b1, gate_output);
    chk_pin("pg_oe", 1'b0, pg_oe);
    vdd_cmp <= 1'b0;
    wt(60);
    chk_pin("gate_output", 1'b0, gate_output);
    chk_pin("pg_oe", 1'b1, pg_oe);
    chk_pin("sensor_pwm_out", 1'b0, sensor_pwm_out);
    chk_pin("vdd_ref_high", 1'b1, vdd_ref_high);
    vdd_cmp <= 1'b1;
    wt(80);
    chk_pin("gate_output", 1'b1, gate_output);
    vcc_cmp <= 1'b0;
    wt(60);
    chk_pin("gate_output", 1'b0, gate_output);
    vcc_cmp <= 1'b1;
    wt(80);
    chk_pin("gate_output", 1'b1, gate_output);
    done("lockout");
    overcurrent_sense <= 1'b1;
    wt(5);
    chk_pin("gate_soft_off", 1'b1, gate_soft_off);
    chk_pin("gate_output", 1'b0, gate_output);
    chk_pin("fault_out_n_oe", 1'b1, fault_out_n_oe);
    overcurrent_sense <= 1'b0;
    gdp_host_model_i.clear_req(30);
    wt(20);
    chk_pin("fault_out_n_oe", 1'b1, fault_out_n_oe);
    wt(10);
    chk_pin("gate_pull_low", 1'b1, gate_pull_low);
    chk_pin("gate_output", 1'b0, gate_output);
    rd_chk("fcnt", 32'h8, 32'h1);
    gdp_host_model_i.clear_req(40);
    wt(25);
    chk_pin("fault_out_n_oe", 1'b0, fault_out_n_oe);
    wt(20);
    chk_pin("gate_output", 1'b1, gate_output);
    done("fault");
    gdp_host_model_i.set_en(1'b0);
    wt(75);
    chk_pin("gate_output", 1'b0, gate_output);
    chk_pin("gate_soft_off", 1'b1, gate_soft_off);
    bus(1'b0, 32'h4, 32'h0, q);
    chk_pin("disabled", 1'b1, q[3]);
    gdp_host_model_i.set_en(1'b1);
    wt(90);
    chk_pin("gate_output", 1'b1, gate_output);
    done("disable");
    bus(1'b1, 32'h0, 32'h3, q);
    rd_chk("ctrl", 32'h0, 32'h3);
    wt(5);
    chk_pin("gate_output", 1'b0, gate_output);
    bus(1'b1, 32'h0, 32'h2, q);
    wt(80);
    chk_pin("gate_output", 1'b1, gate_output);
    done("force off");
    close_out();
  end
endmodule
